/* logic/sps_pkg.sv */
package sps_pkg;

	// Printed offsets are register indices; byte address is four times the index
	localparam logic [7:0] IDX_PAGE_STACK_NEXT = 8'h85;
	localparam logic [7:0] IDX_PAGE_STACK_LAST = 8'h86;
	localparam logic [7:0] IDX_PAGE_SELECT     = 8'hA7;
	localparam logic [7:0] IDX_PAGE_CONTROL    = 8'hE5;

	localparam int         ADR_W               = 12;
	localparam int         DAT_W               = 32;
	localparam int         PAGE_W              = 8;

	localparam logic [7:0] PAGE_ZERO           = 8'h00;
	localparam logic [7:0] PAGE_SELECT_RESET   = 8'h00;
	localparam logic [7:0] PAGE_STACK_RESET    = 8'h00;
	localparam logic [7:0] PAGE_CONTROL_RESET  = 8'h01;
	localparam logic [7:0] PAGE_CONTROL_PAGE   = 8'h0F;
	localparam int         AUTO_PAGE_EN_BIT    = 0;
	localparam logic [7:0] PAGE_CONTROL_RSVD   = 8'hFE;
	localparam logic [31:0] DAT_ZERO           = 32'h0000_0000;

	typedef struct packed
	{
		logic                cyc;
		logic                stb;
		logic                we;
		logic [ADR_W-1:0]    adr;
		logic [DAT_W-1:0]    dat;
		logic [3:0]          sel;
	} sps_wb_req_t;

	typedef struct packed
	{
		logic irq_enter;
		logic irq_return;
	} sps_core_evt_t;

	function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
		reg_hit = (adr == {2'b00, idx, 2'b00});
	endfunction

	function automatic logic [DAT_W-1:0] widen(input logic [PAGE_W-1:0] b);
		widen = {24'h00_0000, b};
	endfunction

endpackage

/* logic/sps_page_stack.sv */
`timescale 1ns/10ps
module sps_page_stack (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       push_i,
	input  wire logic       pop_i,
	input  wire logic       wr_top_i,
	input  wire logic       wr_next_i,
	input  wire logic       wr_last_i,
	input  wire logic [7:0] wr_data_i,
	output logic      [7:0] top_o,
	output logic      [7:0] next_o,
	output logic      [7:0] last_o
);

	typedef struct packed
	{
		logic [7:0] top;
		logic [7:0] next;
		logic [7:0] last;
	} sps_stack_state_t;

	sps_stack_state_t s_reg;
	sps_stack_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		// Hardware push/pop beats a software write in the same cycle
		if (push_i)
		begin
			s_next.last = s_reg.next;
			s_next.next = s_reg.top;
			s_next.top  = sps_pkg::PAGE_ZERO;
		end
		else if (pop_i)
		begin
			s_next.top  = s_reg.next;
			s_next.next = s_reg.last;
			s_next.last = sps_pkg::PAGE_STACK_RESET;
		end
		else
		begin
			if (wr_top_i)
				s_next.top = wr_data_i;
			if (wr_next_i)
				s_next.next = wr_data_i;
			if (wr_last_i)
				s_next.last = wr_data_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_reg.top  <= sps_pkg::PAGE_SELECT_RESET;
			s_reg.next <= sps_pkg::PAGE_STACK_RESET;
			s_reg.last <= sps_pkg::PAGE_STACK_RESET;
		end
		else
			s_reg <= s_next;
	end

	assign top_o  = s_reg.top;
	assign next_o = s_reg.next;
	assign last_o = s_reg.last;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	property p_push_shift;
		push_i |=> (top_o == sps_pkg::PAGE_ZERO) && (next_o == $past(top_o)) && (last_o == $past(next_o));
	endproperty
	a_push_shift: assert property (p_push_shift) else $error("push did not shift stack");

	property p_pop_shift;
		(pop_i && !push_i) |=> (top_o == $past(next_o)) && (next_o == $past(last_o));
	endproperty
	a_pop_shift: assert property (p_pop_shift) else $error("pop did not restore stack");

endmodule

/* logic/sps_top.sv */
// Function
// - A write to the page select register at index 0xA7, reachable on every page, sets the active register page.
// - A read of the page select register returns the page currently in use.
// - With automatic paging on, interrupt entry switches the active page to page 0.
// - With automatic paging on, interrupt return restores the earlier page unless software edited the stack.
// - The page select register is the stack top and only interrupt entry and return push or pop the stack.
// - Bit 0 of the page control register at index 0xE5 enables automatic paging and resets to 1.
// - With automatic paging off, taking an interrupt leaves the active page unchanged.
// - Page control bits 7 to 1 read as zero and software writes zeros there.
// - The page select register resets to page 0x00.
// - The next and last stack entries read at indices 0x85 and 0x86 from every page.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
module sps_top (
	input  wire logic                   clock_i,
	input  wire logic                   rst_n_i,
	input  wire sps_pkg::sps_wb_req_t   wb_req_i,
	output logic [sps_pkg::DAT_W-1:0]   wb_dat_o,
	output logic                        wb_ack_o,
	input  wire sps_pkg::sps_core_evt_t core_evt_i,
	output logic [sps_pkg::PAGE_W-1:0]  active_page_o,
	output logic                        auto_page_enable_o
);

	typedef struct packed
	{
		logic                      ack;
		logic [sps_pkg::DAT_W-1:0] rdat;
		logic                      auto_en;
	} sps_top_state_t;

	sps_top_state_t s_reg;
	sps_top_state_t s_next;

	logic       req_fire;
	logic       wr_fire;
	logic       rd_fire;
	logic       hit_select;
	logic       hit_next;
	logic       hit_last;
	logic       hit_control;
	logic       push;
	logic       pop;
	logic       wr_top;
	logic       wr_next;
	logic       wr_last;
	logic [7:0] wr_byte;
	logic [7:0] page_top;
	logic [7:0] page_next;
	logic [7:0] page_last;

	// Single-cycle answer: a request is taken only while ack is low
	assign req_fire    = wb_req_i.cyc & wb_req_i.stb & ~s_reg.ack;
	// Only lane 0 carries register data; other lanes are ignored
	assign wr_fire     = req_fire & wb_req_i.we & wb_req_i.sel[0];
	assign rd_fire     = req_fire & ~wb_req_i.we;
	assign wr_byte     = wb_req_i.dat[7:0];

	assign hit_select  = sps_pkg::reg_hit(wb_req_i.adr, sps_pkg::IDX_PAGE_SELECT);
	assign hit_next    = sps_pkg::reg_hit(wb_req_i.adr, sps_pkg::IDX_PAGE_STACK_NEXT);
	assign hit_last    = sps_pkg::reg_hit(wb_req_i.adr, sps_pkg::IDX_PAGE_STACK_LAST);
	// Page control lives only on its own page; elsewhere that index reads zero
	assign hit_control = sps_pkg::reg_hit(wb_req_i.adr, sps_pkg::IDX_PAGE_CONTROL)
	                   & (page_top == sps_pkg::PAGE_CONTROL_PAGE);

	// Interrupt events act only with automatic paging on
	assign push        = core_evt_i.irq_enter & s_reg.auto_en;
	// Entry wins when both arrive together
	assign pop         = core_evt_i.irq_return & s_reg.auto_en & ~core_evt_i.irq_enter;

	assign wr_top      = wr_fire & hit_select;
	assign wr_next     = wr_fire & hit_next;
	assign wr_last     = wr_fire & hit_last;

	sps_page_stack u_stack (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_i),
		.push_i    (push),
		.pop_i     (pop),
		.wr_top_i  (wr_top),
		.wr_next_i (wr_next),
		.wr_last_i (wr_last),
		.wr_data_i (wr_byte),
		.top_o     (page_top),
		.next_o    (page_next),
		.last_o    (page_last)
	);

	always_comb
	begin
		s_next     = s_reg;
		s_next.ack = req_fire;
		if (rd_fire)
		begin
			if (hit_select)
				s_next.rdat = sps_pkg::widen(page_top);
			else if (hit_next)
				s_next.rdat = sps_pkg::widen(page_next);
			else if (hit_last)
				s_next.rdat = sps_pkg::widen(page_last);
			else if (hit_control)
				s_next.rdat = sps_pkg::widen({7'h00, s_reg.auto_en});
			else
				s_next.rdat = sps_pkg::DAT_ZERO;
		end
		// Reserved control bits are dropped on write so they always read zero
		if (wr_fire & hit_control)
			s_next.auto_en = wr_byte[sps_pkg::AUTO_PAGE_EN_BIT];
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_reg.ack     <= 1'b0;
			s_reg.rdat    <= sps_pkg::DAT_ZERO;
			s_reg.auto_en <= sps_pkg::PAGE_CONTROL_RESET[sps_pkg::AUTO_PAGE_EN_BIT];
		end
		else
			s_reg <= s_next;
	end

	assign wb_ack_o           = s_reg.ack;
	assign wb_dat_o           = s_reg.rdat;
	assign active_page_o      = page_top;
	assign auto_page_enable_o = s_reg.auto_en;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	property p_page_write;
		(wr_top && !core_evt_i.irq_enter && !core_evt_i.irq_return) |=> (active_page_o == $past(wr_byte));
	endproperty
	a_page_write: assert property (p_page_write) else $error("page select write not applied");

	property p_page_read;
		(rd_fire && hit_select) |=> wb_ack_o && (wb_dat_o == sps_pkg::widen($past(active_page_o)));
	endproperty
	a_page_read: assert property (p_page_read) else $error("page select read wrong");

	property p_irq_zero;
		(core_evt_i.irq_enter && auto_page_enable_o) |=> (active_page_o == sps_pkg::PAGE_ZERO);
	endproperty
	a_irq_zero: assert property (p_irq_zero) else $error("interrupt entry did not select page 0");

	sequence s_quiet;
		!core_evt_i.irq_enter && !core_evt_i.irq_return && !wr_fire;
	endsequence

	sequence s_enter_return;
		(core_evt_i.irq_enter && auto_page_enable_o && !core_evt_i.irq_return && !wr_fire)
		##1 (s_quiet and (auto_page_enable_o == 1'b1))
		##1 (core_evt_i.irq_return && !core_evt_i.irq_enter && !wr_fire);
	endsequence

	property p_irq_restore;
		s_enter_return |=> (active_page_o == $past(active_page_o, 3));
	endproperty
	a_irq_restore: assert property (p_irq_restore) else $error("page not restored on return");

	property p_no_push_on_access;
		(req_fire && hit_select && !core_evt_i.irq_enter && !core_evt_i.irq_return)
		|=> $stable(page_next) && $stable(page_last);
	endproperty
	a_no_push_on_access: assert property (p_no_push_on_access) else $error("register access moved stack");

	property p_ctrl_write;
		(wr_fire && hit_control) |=> (auto_page_enable_o == $past(wr_byte[sps_pkg::AUTO_PAGE_EN_BIT]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("page control write not applied");

	property p_irq_disabled;
		(core_evt_i.irq_enter && !auto_page_enable_o && !wr_top) |=> $stable(active_page_o);
	endproperty
	a_irq_disabled: assert property (p_irq_disabled) else $error("page changed with paging off");

	property p_ctrl_reserved;
		(rd_fire && hit_control) |=> (wb_dat_o[7:1] == 7'h00)
		&& (wb_dat_o[sps_pkg::AUTO_PAGE_EN_BIT] == $past(auto_page_enable_o));
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("page control read wrong");

	property p_stack_read;
		(rd_fire && hit_next) |=> (wb_dat_o == sps_pkg::widen($past(page_next)));
	endproperty
	a_stack_read: assert property (p_stack_read) else $error("stack next read wrong");

	property p_ack_drop;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held two cycles");

endmodule

/* tb/sps_core_model.sv */
`timescale 1ns/10ps
module sps_core_model (
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             enter_i,
	input  wire logic             return_i,
	output sps_pkg::sps_core_evt_t evt_o
);
	// Registered, so every event follows its request one clock later and lasts as long as it
	always_ff @(posedge clock_i or negedge rst_n_i)
		if (!rst_n_i)
			evt_o <= '0;
		else
			evt_o <= '{irq_enter: enter_i, irq_return: return_i};
endmodule

/* tb/sfr_page_select_stack_tb_top.sv */
`timescale 1ns/10ps
module sfr_page_select_stack_tb_top;
	logic                   clock_i = 1'h0;
	logic                   rst_n_i = 1'h0;
	sps_pkg::sps_wb_req_t   req = '0;
	sps_pkg::sps_core_evt_t evt;
	logic [31:0]            dat;
	logic                   ack;
	logic [7:0]             pg;
	logic                   aen;
	logic                   ent = 1'h0;
	logic                   ret = 1'h0;
	logic [31:0]            rd;
	logic [7:0]             p;
	logic [23:0]            ms;
	logic [1:0]             k;
	logic [3:0]             bsel = 4'hF;
	int                     error_cnt = 0;
	int                     n_checks = 0;
	int                     seed = 16959;

	always #25 clock_i = ~clock_i;

	sps_top sps_top_i (
		.clock_i            (clock_i),
		.rst_n_i            (rst_n_i),
		.wb_req_i           (req),
		.wb_dat_o           (dat),
		.wb_ack_o           (ack),
		.core_evt_i         (evt),
		.active_page_o      (pg),
		.auto_page_enable_o (aen)
	);

	sps_core_model sps_core_model_i (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n_i),
		.enter_i  (ent),
		.return_i (ret),
		.evt_o    (evt)
	);

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Model stack packed as top, next, last; entry wins over return
	function automatic logic [23:0] st_evt(input logic [23:0] s, input logic e, input logic r, input logic en);
		if (!en)
			return s;
		if (e)
			return {8'h00, s[23:8]};
		if (r)
			return {s[15:0], 8'h00};
		return s;
	endfunction

	// Ack is looked at as sampled on the edge, before this edge's updates
	task bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
		int i;
		@(posedge clock_i);
		req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: {2'h0, idx, 2'h0}, dat: {24'h00_0000, d}, sel: bsel};
		for (i = 0; i < 20; i++)
		begin
			@(posedge clock_i);
			if (ack === 1'h1)
				break;
		end
		if (i == 20)
		begin
			error_cnt++;
			report_and_stop();
		end
		rd = dat;
		req <= '0;
	endtask

	// One-cycle request to the core model; the event reaches the stack two edges later
	task pulse(input logic e, input logic r);
		@(posedge clock_i);
		ent <= e;
		ret <= r;
		@(posedge clock_i);
		ent <= 1'h0;
		ret <= 1'h0;
	endtask

	task irq(input logic e);
		pulse(e, ~e);
		@(posedge clock_i);
		#1;
	endtask

	initial
	begin
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'h1;
		bus(1'h0, sps_pkg::IDX_PAGE_SELECT, 8'h00);
		chk("page_select", rd, 32'h0000_0000);
		chk("auto_en", {31'h0, aen}, 32'h0000_0001);
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, 8'h0F);
		bus(1'h0, sps_pkg::IDX_PAGE_CONTROL, 8'h00);
		chk("page_control", rd, 32'h0000_0001);
		$display("test reset done");
		repeat (4)
		begin
			p = 8'($random(seed));
			bus(1'h1, sps_pkg::IDX_PAGE_SELECT, p);
			chk("active_page", {24'h0, pg}, {24'h0, p});
			bus(1'h0, sps_pkg::IDX_PAGE_SELECT, 8'h00);
			chk("page_select", rd, {24'h0, p});
			bus(1'h0, sps_pkg::IDX_PAGE_STACK_NEXT, 8'h00);
			chk("stack_next", rd, 32'h0000_0000);
		end
		$display("test page write done");
		p = 8'($random(seed));
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, p);
		irq(1'h1);
		chk("active_page", {24'h0, pg}, 32'h0000_0000);
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, ~p);
		irq(1'h1);
		bus(1'h0, sps_pkg::IDX_PAGE_STACK_NEXT, 8'h00);
		chk("stack_next", rd, {24'h0, ~p});
		bus(1'h0, sps_pkg::IDX_PAGE_STACK_LAST, 8'h00);
		chk("stack_last", rd, {24'h0, p});
		irq(1'h0);
		chk("active_page", {24'h0, pg}, {24'h0, ~p});
		irq(1'h0);
		chk("active_page", {24'h0, pg}, {24'h0, p});
		irq(1'h1);
		bus(1'h1, sps_pkg::IDX_PAGE_STACK_NEXT, p ^ 8'h3C);
		irq(1'h0);
		chk("active_page", {24'h0, pg}, {24'h0, p ^ 8'h3C});
		$display("test auto paging done");
		// Control register is refused off its page; lane 0 deselected write is dropped
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, 8'h0E);
		bus(1'h1, sps_pkg::IDX_PAGE_CONTROL, 8'h00);
		chk("auto_en", {31'h0, aen}, 32'h0000_0001);
		bus(1'h0, sps_pkg::IDX_PAGE_CONTROL, 8'h00);
		chk("page_control", rd, 32'h0000_0000);
		bsel = 4'hE;
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, 8'h5A);
		bsel = 4'hF;
		chk("active_page", {24'h0, pg}, 32'h0000_000E);
		// Entry, one quiet cycle, return: tightest nesting
		p = 8'($random(seed));
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, p);
		pulse(1'h1, 1'h0);
		irq(1'h0);
		chk("active_page", {24'h0, pg}, {24'h0, p});
		pulse(1'h1, 1'h1);
		@(posedge clock_i);
		#1;
		chk("active_page", {24'h0, pg}, 32'h0000_0000);
		bus(1'h0, sps_pkg::IDX_PAGE_STACK_NEXT, 8'h00);
		chk("stack_next", rd, {24'h0, p});
		ms[23:16] = 8'($random(seed));
		ms[15:8] = 8'($random(seed));
		ms[7:0] = 8'($random(seed));
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, ms[23:16]);
		bus(1'h1, sps_pkg::IDX_PAGE_STACK_NEXT, ms[15:8]);
		bus(1'h1, sps_pkg::IDX_PAGE_STACK_LAST, ms[7:0]);
		repeat (16)
		begin
			k = 2'($random(seed));
			pulse(k[1], k[0]);
			@(posedge clock_i);
			#1;
			ms = st_evt(ms, k[1], k[0], 1'h1);
			chk("active_page", {24'h0, pg}, {24'h0, ms[23:16]});
			bus(1'h0, sps_pkg::IDX_PAGE_STACK_NEXT, 8'h00);
			chk("stack_next", rd, {24'h0, ms[15:8]});
			bus(1'h0, sps_pkg::IDX_PAGE_STACK_LAST, 8'h00);
			chk("stack_last", rd, {24'h0, ms[7:0]});
		end
		$display("test random stack done");
		bus(1'h1, sps_pkg::IDX_PAGE_SELECT, 8'h0F);
		bus(1'h1, sps_pkg::IDX_PAGE_CONTROL, 8'h00);
		chk("auto_en", {31'h0, aen}, 32'h0000_0000);
		irq(1'h1);
		chk("active_page", {24'h0, pg}, 32'h0000_000F);
		irq(1'h0);
		chk("active_page", {24'h0, pg}, 32'h0000_000F);
		bus(1'h0, 8'h33, 8'h00);
		chk("unmapped", rd, 32'h0000_0000);
		$display("test auto off done");
		@(posedge clock_i);
		rst_n_i <= 1'h0;
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'h1;
		chk("active_page", {24'h0, pg}, 32'h0000_0000);
		chk("auto_en", {31'h0, aen}, 32'h0000_0001);
		bus(1'h0, sps_pkg::IDX_PAGE_SELECT, 8'h00);
		chk("page_select", rd, 32'h0000_0000);
		bus(1'h0, sps_pkg::IDX_PAGE_STACK_LAST, 8'h00);
		chk("stack_last", rd, 32'h0000_0000);
		$display("test mid reset done");
		report_and_stop();
	end
endmodule
